// *** src/eic_top.sv ***
// Purpose: external interrupt sense, priority and low-power wake control
// Assumes: pins and cpu signals synchronous to clk; cpu gives mask level and service handshake
// Notes: sources 0..5 = three port pin groups, portf, timer, top level; higher index wins
`timescale 1ns/1ps
`include "eic_params.svh"

// How it works
// [RQ1] portb sense field picks portb triggers
// [RQ2] portb polarity bit inverts low-nibble trigger
// [RQ3] second field picks porta and portf triggers
// [RQ4] porta polarity bit inverts porta trigger
// [RQ5] sense and polarity writable only at level 3
// [RQ6] edge select changes only while disabled
// [RQ7] enable bit gates top-level pin detection
// [RQ8] clearing enable may raise one spurious request
// [RQ9] control register resets to zero
// [RQ10] any pending unmasked source ends wait
// [RQ11] only halt-capable sources end halt
// [RQ12] first service after halt is halt-capable
// [RQ13] other sources wait for that first service
// [RQ14] fixed priority top level above sources zero..four
// [RQ15] concurrent mode forbids preemption, nested allows
// [RQ16] pins synchronised, edges from consecutive samples
// [RQ17] level codes keep requesting while level holds
module eic_top import eic_pkg::*; #(
  parameter int NSRC = `EIC_NSRC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire eic_bus_s bus,
  output logic [7:0] rdata,
  input wire logic porta_low_nibble_irq,
  input wire logic portf_irq,
  input wire logic portb_low_nibble_irq,
  input wire logic portb_high_nibble_irq,
  input wire logic top_level_interrupt,
  input wire logic timer_irq,
  input wire logic cpu_mask_bit_high,
  input wire logic cpu_mask_bit_low,
  input wire logic nested_mode,
  input wire logic wait_enter,
  input wire logic halt_enter,
  input wire logic service_ack,
  input wire logic service_done,
  output logic [2:0] irq_vector,
  output logic irq_req,
  output logic cpu_wake,
  output logic irq
);
  eic_ctrl_s ctrl_q;
  logic [NSRC-1:0] stat_q;
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] halt_cap_q;
  logic [NSRC-1:0] pin_s0_q;
  logic [NSRC-1:0] pin_s1_q;
  logic [NSRC-1:0] pin_prev_q;
  logic [NSRC-1:0] hit;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] pins;
  logic [1:0] sense [NSRC];
  logic [NSRC-1:0] inv;
  logic tle_fall;
  logic lvl3;
  logic busy_q;
  logic [2:0] active_q;
  logic [2:0] win;
  logic win_ok;
  eic_pwr_e pwr_q;
  logic first_halt_q;

  assign lvl3 = {cpu_mask_bit_high, cpu_mask_bit_low} == `EIC_LVL3;
  assign pins = {top_level_interrupt, timer_irq, porta_low_nibble_irq, portf_irq,
                 portb_low_nibble_irq, portb_high_nibble_irq};

  // source map: 0 portb high, 1 portb low, 2 portf, 3 porta low, 4 timer, 5 top level
  always_comb begin
    sense[0] = ctrl_q.portb_sense_field; // see [RQ1]
    sense[1] = ctrl_q.portb_sense_field;
    sense[2] = ctrl_q.porta_portf_sense_field; // see [RQ3]
    sense[3] = ctrl_q.porta_portf_sense_field;
    sense[4] = EIC_SENSE_RISE;
    sense[5] = ctrl_q.top_level_edge_select ? EIC_SENSE_RISE : EIC_SENSE_FALL; // see [RQ6]
    inv = '0;
    inv[1] = ctrl_q.portb_polarity_invert; // see [RQ2]
    inv[3] = ctrl_q.porta_polarity_invert; // see [RQ4]
  end

  // clearing the enable while the pin sits at its active level lets one request through
  assign tle_fall = ctrl_q.top_level_irq_enable && bus.wr && bus.addr == `EIC_OFF_CTRL &&
                    !bus.wdata[`EIC_BIT_TLE] && (pin_s1_q[`EIC_SRC_TOP] == ctrl_q.top_level_edge_select); // see [RQ8]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s0_q <= '0;
      pin_s1_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_s0_q <= pins; // see [RQ16]
      pin_s1_q <= pin_s0_q;
      pin_prev_q <= pin_s1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_det
      logic cur;
      logic prv;
      logic rise;
      logic fall;
      always_comb begin
        // inversion swaps the roles of the two levels, so both-edge code stays both
        cur = pin_s1_q[gi] ^ inv[gi];
        prv = pin_prev_q[gi] ^ inv[gi];
        rise = cur && !prv; // see [RQ16]
        fall = !cur && prv;
        hit[gi] = 1'b0;
        // the timer source runs through the same detector with a fixed rising code
        case (sense[gi])
          EIC_SENSE_FALL_LOW: hit[gi] = !cur; // see [RQ17]
          EIC_SENSE_RISE: hit[gi] = rise;
          EIC_SENSE_FALL: hit[gi] = fall;
          EIC_SENSE_BOTH: hit[gi] = rise || fall;
          default: hit[gi] = 1'b0;
        endcase
        if (gi == `EIC_SRC_TOP) begin
          hit[gi] = (hit[gi] && ctrl_q.top_level_irq_enable) || tle_fall; // see [RQ7]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `EIC_CTRL_RST; // see [RQ9]
    end else if (bus.wr && bus.addr == `EIC_OFF_CTRL) begin
      if (lvl3) begin
        ctrl_q.portb_sense_field <= bus.wdata[`EIC_BIT_IS1 +: 2]; // see [RQ5]
        ctrl_q.portb_polarity_invert <= bus.wdata[`EIC_BIT_IPB];
        ctrl_q.porta_portf_sense_field <= bus.wdata[`EIC_BIT_IS2 +: 2];
        ctrl_q.porta_polarity_invert <= bus.wdata[`EIC_BIT_IPA];
      end
      if (!ctrl_q.top_level_irq_enable) begin
        ctrl_q.top_level_edge_select <= bus.wdata[`EIC_BIT_TLS]; // see [RQ6]
      end
      ctrl_q.top_level_irq_enable <= bus.wdata[`EIC_BIT_TLE]; // see [RQ7]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= `EIC_MASK_RST;
      halt_cap_q <= `EIC_HALT_RST;
    end else if (bus.wr) begin
      if (bus.addr == `EIC_OFF_MASK) begin
        mask_q <= bus.wdata[NSRC-1:0];
      end
      if (bus.addr == `EIC_OFF_HALT) begin
        halt_cap_q <= bus.wdata[NSRC-1:0];
      end
    end
  end

  // pending flags: hardware set wins over write-one-to-clear and over service ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (hit[i]) begin
          stat_q[i] <= 1'b1;
        end else if ((bus.wr && bus.addr == `EIC_OFF_STAT && bus.wdata[i]) ||
                     (service_ack && irq_req && win == 3'(i))) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // external pins always leave halt; timer only if software marks it halt-capable
  always_comb begin
    elig = stat_q & mask_q;
    if (pwr_q == EIC_HALT || first_halt_q) begin
      elig = elig & (halt_cap_q | NSRC'(`EIC_HALT_PINS)); // see [RQ11] see [RQ12] see [RQ13]
    end
  end

  always_comb begin
    win = '0;
    win_ok = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (elig[i]) begin
        win = 3'(i); // see [RQ14]
        win_ok = 1'b1;
      end
    end
  end

  // concurrent mode holds requests while a service runs; nested only lets higher ones in
  assign irq_req = win_ok && pwr_q != EIC_HALT &&
                   (!busy_q || (nested_mode && win > active_q)); // see [RQ15]
  assign irq_vector = win;
  assign irq = |(stat_q & mask_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      active_q <= '0;
    end else if (service_ack && irq_req) begin
      busy_q <= 1'b1;
      active_q <= win;
    end else if (service_done) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_q <= EIC_RUN;
      first_halt_q <= 1'b0;
      cpu_wake <= 1'b0;
    end else begin
      cpu_wake <= 1'b0;
      case (pwr_q)
        EIC_RUN: begin
          if (halt_enter) begin
            pwr_q <= EIC_HALT;
          end else if (wait_enter) begin
            pwr_q <= EIC_WAIT;
          end
          if (first_halt_q && service_done) begin
            first_halt_q <= 1'b0; // see [RQ13]
          end
        end
        EIC_WAIT: begin
          if (|(stat_q & mask_q)) begin
            pwr_q <= EIC_RUN; // see [RQ10]
            cpu_wake <= 1'b1;
          end
        end
        EIC_HALT: begin
          if (win_ok) begin
            pwr_q <= EIC_RUN; // see [RQ11]
            cpu_wake <= 1'b1;
            first_halt_q <= 1'b1;
          end
        end
        default: pwr_q <= EIC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `EIC_OFF_CTRL: rdata <= ctrl_q;
        `EIC_OFF_STAT: rdata <= 8'(stat_q);
        `EIC_OFF_MASK: rdata <= 8'(mask_q);
        `EIC_OFF_HALT: rdata <= 8'(halt_cap_q);
        `EIC_OFF_PEND: rdata <= {busy_q, first_halt_q, pwr_q, 1'b0, active_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : eic_top

// *** src/eic_params.svh ***
// Purpose: constants of the external interrupt control block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: offsets are word indices on the plain register port
`ifndef EIC_PARAMS_SVH
`define EIC_PARAMS_SVH
`define EIC_ADDR_W 4
`define EIC_OFF_CTRL 4'h0
`define EIC_OFF_STAT 4'h1
`define EIC_OFF_MASK 4'h2
`define EIC_OFF_HALT 4'h3
`define EIC_OFF_PEND 4'h4
`define EIC_CTRL_RST 8'h00
`define EIC_BIT_TLE 0
`define EIC_BIT_TLS 1
`define EIC_BIT_IPA 2
`define EIC_BIT_IPB 5
`define EIC_BIT_IS2 3
`define EIC_BIT_IS1 6
`define EIC_HALT_PINS 6'h2F
`define EIC_NSRC 6
`define EIC_SRC_TOP 5
`define EIC_HALT_RST 6'h00
`define EIC_MASK_RST 6'h00
`define EIC_LVL3 2'h3
`endif

// *** src/eic_pkg.sv ***
// Purpose: types of the external interrupt control block
// Assumes: constants come from eic_params.svh
// Notes: source index 0 is lowest hardware priority
package eic_pkg;
  typedef enum logic [1:0] {
    EIC_SENSE_FALL_LOW,
    EIC_SENSE_RISE,
    EIC_SENSE_FALL,
    EIC_SENSE_BOTH
  } eic_sense_e;
  typedef struct packed {
    logic [1:0] portb_sense_field;
    logic portb_polarity_invert;
    logic [1:0] porta_portf_sense_field;
    logic porta_polarity_invert;
    logic top_level_edge_select;
    logic top_level_irq_enable;
  } eic_ctrl_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eic_bus_s;
  typedef enum logic [1:0] {
    EIC_RUN,
    EIC_WAIT,
    EIC_HALT,
    EIC_HALT_EXIT
  } eic_pwr_e;
endpackage : eic_pkg

// *** dv/eic_monitor.sv ***
// Purpose: port checks of eic_top
// Assumes: sync reset sys_rst, one clock
// Notes: outputs only, never inputs
`timescale 1ns/1ps
module eic_monitor import eic_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire eic_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic nested_mode,
  input wire logic service_ack,
  input wire logic irq_req,
  input wire logic [2:0] irq_vector,
  input wire logic cpu_wake,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ack;
    service_ack && irq_req;
  endsequence
  rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> rdata == 8'h00 && !cpu_wake && !irq)
    else $error("outputs not cleared by reset");
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  unmap_rd_a: assert property (bus.rd && bus.addr > 4'h4 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  conc_hold_a: assert property (s_ack ##0 !nested_mode |=> !irq_req)
    else $error("request during concurrent service");
  nest_rank_a: assert property (s_ack ##0 nested_mode |=> !irq_req || irq_vector > $past(irq_vector))
    else $error("nested request not higher");
  wake_pulse_a: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake longer than one cycle");
  vec_range_a: assert property (irq_req |-> irq_vector <= 3'h5)
    else $error("vector out of range");
  irq_hold_a: assert property (irq && !bus.wr && !service_ack |=> irq)
    else $error("interrupt dropped without clear");
endmodule : eic_monitor
bind eic_top eic_monitor u_eic_monitor (.clk, .sys_rst, .bus, .rdata, .nested_mode,
  .service_ack, .irq_req, .irq_vector, .cpu_wake, .irq);

// *** dv/eic_cpu_model.sv ***
// Purpose: cpu side service handshake
// Assumes: one service open at a time
// Notes: slow stretches each service
`timescale 1ns/1ps
module eic_cpu_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic en,
  input wire logic slow,
  input wire logic irq_req,
  output logic service_ack,
  output logic service_done
);
  int cnt_q;
  always_ff @(posedge clk) begin
    service_ack <= 1'b0;
    service_done <= 1'b0;
    if (sys_rst) begin
      cnt_q <= 0;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end else if (cnt_q == 1) begin
      cnt_q <= 0;
      service_done <= 1'b1;
    end else if (en && irq_req && !service_ack && !service_done) begin
      service_ack <= 1'b1;
      cnt_q <= slow ? 9 : 2;
    end
  end
endmodule : eic_cpu_model

// *** dv/eic_top_tb_top.sv ***
// Purpose: self-checking bench of eic_top
// Assumes: 25 MHz clock, sync reset
// Notes: ctrl model kept in cm
`timescale 1ns/1ps
module eic_top_tb_top import eic_pkg::*; ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  eic_bus_s b = '0;
  logic [7:0] rdata, r, cm = 8'h00;
  logic [4:0] p = '0;
  logic tmr = 0, mh = 0, ml = 0, nest = 0, we = 0, he = 0, en = 0, slow = 0;
  logic ack, done, req, wake, irq;
  logic [2:0] vec;
  int errors = 0, n_checks = 0, d;
  eic_top u_eic_top (.clk, .sys_rst, .bus(b), .rdata, .porta_low_nibble_irq(p[3]), .portf_irq(p[2]),
    .portb_low_nibble_irq(p[1]), .portb_high_nibble_irq(p[0]), .top_level_interrupt(p[4]),
    .timer_irq(tmr), .cpu_mask_bit_high(mh), .cpu_mask_bit_low(ml), .nested_mode(nest),
    .wait_enter(we), .halt_enter(he), .service_ack(ack), .service_done(done),
    .irq_vector(vec), .irq_req(req), .cpu_wake(wake), .irq);
  eic_cpu_model u_eic_cpu_model (.clk, .sys_rst, .en, .slow, .irq_req(req),
    .service_ack(ack), .service_done(done));
  initial forever #20 clk = ~clk;
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) b <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) b.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk) b <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) b.rd <= 1'b0;
    #1 r = rdata;
  endtask : rd
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // the whole run needs some 2000 cycles
  initial begin
    #2000000;
    errors++;
    end_sim;
  end
  initial begin
    void'($urandom(75060));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0);
    chk(8'h00, r);
    rd(4'hF);
    chk(8'h00, r);
    repeat (24) begin
      d = $urandom;
      @(posedge clk) {mh, ml} <= d[9:8];
      wr(4'h0, d[7:0]);
      cm = {(d[9:8] == 2'h3) ? d[7:2] : cm[7:2], cm[0] ? cm[1] : d[1], d[0]};
      rd(4'h0);
      chk(cm, r);
    end
    @(posedge clk) {mh, ml} <= 2'h3;
    wr(4'h2, 8'h3F);
    // both fields share code and polarity; only the pin under test is judged
    for (int i = 0; i < 80; i++) begin
      int k;
      logic [1:0] c;
      logic [7:0] v;
      logic pl, t, ip, ex;
      k = i / 16;
      c = i[3:2];
      pl = i[1];
      t = i[0];
      v = {c, pl, c, pl, c[0], c[1]};
      ip = pl && (k == 1 || k == 3);
      ex = (k == 4) ? (c[1] && t == c[0]) : (c == 0 || c == 3 || (c == 1) == (t ^ ip));
      wr(4'h0, v & 8'hFE);
      wr(4'h0, v);
      @(posedge clk) p[k] <= !t;
      repeat (5) @(posedge clk);
      wr(4'h1, 8'h3F);
      @(posedge clk) p[k] <= t;
      repeat (5) @(posedge clk);
      rd(4'h1);
      chk({7'h0, ex}, {7'h0, r[k == 4 ? 5 : k]});
    end
    @(posedge clk) p <= '0;
    wr(4'h0, 8'h48);
    repeat (5) @(posedge clk);
    wr(4'h1, 8'h3F);
    @(posedge clk) p[0] <= 1'b1;
    repeat (5) @(posedge clk);
    chk(8'h01, {7'h0, irq});
    wr(4'h2, 8'h00);
    #1 chk(8'h00, {7'h0, irq});
    wr(4'h2, 8'h3F);
    #1 chk(8'h01, {7'h0, irq});
    wr(4'h1, 8'h01);
    #1 chk(8'h00, {7'h0, irq});
    for (int n = 0; n < 2; n++) begin
      @(posedge clk) p <= '0;
      nest <= n[0];
      slow <= n[0];
      en <= 1'b1;
      repeat (5) @(posedge clk);
      p <= 5'h09;
      for (int m = 0; m < 2; m++) begin
        repeat (40) begin
          @(posedge clk);
          #1;
          if (ack === 1'b1) break;
        end
        chk(m ? 8'h00 : 8'h03, {5'h00, vec});
      end
    end
    @(posedge clk) en <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      wr(4'h3, j == 0 ? 8'h10 : 8'h00);
      wr(4'h1, 8'h3F);
      @(posedge clk) tmr <= 1'b0;
      {he, we} <= (j == 1) ? 2'b01 : 2'b10;
      @(posedge clk) {he, we} <= 2'b00;
      repeat (3) @(posedge clk);
      tmr <= 1'b1;
      d = 0;
      repeat (20) @(posedge clk) if (wake === 1'b1) d = 1;
      chk({7'h0, j != 2}, 8'(d));
    end
    end_sim;
  end
endmodule : eic_top_tb_top
